// [core/vprs_top.sv]
// Vector priority selector with AHB-Lite register slave
// Behaviour
// - Fixed priority, higher vector address wins unless a maskable source is elevated
// - All three main resets share top slot
// - Clock fail reset only when monitor enabled
// - Watchdog reset only with non-zero rate
// - Unimplemented opcode trap is never maskable
// - Software trap always vectors, never masked
// - Nonmaskable pin gated only by X bit
// - Maskable needs local enable and I clear
// - Elevation code promotes matching maskable source
// - Accumulator overflow slot, own enable bit
// - Accumulator edge slot below overflow slot
// - Motor timer overflow slot and enable
// - Low supply warning slot and enable
// - Main resets above clock fail above watchdog
// - Accept pin, clock unit, regulator resets
// - Reset restores control state, mode strapped
// - No memory array cleared by reset
`timescale 1ns/1ns
module vprs_top
  import vprs_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  // AHB-Lite slave
  input  wire logic                  HSEL,
  input  wire logic [31:0]           HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [31:0]           HWDATA,
  input  wire logic                  HREADY,
  output logic      [31:0]           HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  // Request sources
  input  vprs_pkg::vprs_rst_t        RESET_CAUSE,
  input  wire logic                  UNIMPL_OPCODE_TRAP,
  input  wire logic                  SOFTWARE_TRAP_INSTR,
  input  wire logic                  NONMASKABLE_REQUEST_PIN,
  input  wire logic                  STATUS_X_MASK,
  input  wire logic                  STATUS_I_MASK,
  input  wire logic [63:0]           PERIPH_REQ,
  input  wire logic [1:0]            MODE_STRAP,
  // Results to core and system
  output logic      [15:0]           VECTOR_ADDR,
  output logic                       VECTOR_VALID,
  output logic                       SYSTEM_RESET_REQ,
  output logic      [1:0]            PORT_MODE,
  output logic                       IRQ
);
  import vprs_pkg::*;

  vprs_aphase_t     ap;
  logic             ap_take;
  logic [7:0]       priority_elevate_reg;
  logic [7:0]       watchdog_control_reg;
  logic [31:0]      en_lo;
  logic [31:0]      en_hi;
  logic [ST_W-1:0]  mask;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  st_set;
  logic [ST_W-1:0]  st_clr;
  logic [ST_W-1:0]  ev_prev;
  logic [ST_W-1:0]  ev_now;
  logic [63:0]      usable;
  logic [63:0]      local_en;
  logic [63:0]      pending;
  logic             mask_hit;
  logic [5:0]       mask_slot;
  logic             rst_main;
  logic             clk_ok;
  logic             wdog_ok;
  logic             nonmaskable_request_pin_ok;
  logic             nm_any;
  logic [15:0]      next_vector;
  logic             next_valid;
  logic [31:0]      next_rdata;
  logic             strap_taken;

  // Bus address phase
  assign ap_take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ap <= '0;
    end else if (HREADY) begin
      ap.wr   <= ap_take & HWRITE;
      ap.addr <= HADDR[7:0];
    end
  end

  // Zero wait state slave, every answer OKAY
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Control registers written in the data phase
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      priority_elevate_reg <= ELEVATE_RST;
      watchdog_control_reg <= '0;
      en_lo                <= '0;
      en_hi                <= '0;
      mask                 <= '0;
    end else if (ap.wr) begin
      unique case (ap.addr)
        ADDR_ELEVATE: priority_elevate_reg <= HWDATA[7:0];
        ADDR_WDOG:    watchdog_control_reg <= HWDATA[7:0];
        ADDR_EN_LO:   en_lo                <= HWDATA;
        ADDR_EN_HI:   en_hi                <= HWDATA;
        ADDR_MASK:    mask                 <= HWDATA[ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Mode strap is caught once, just after reset release
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      strap_taken <= 1'b0;
      PORT_MODE   <= '0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      PORT_MODE   <= MODE_STRAP;
    end
  end

  // Read data are taken in the address phase
  always_comb begin
    next_rdata = '0;
    unique case (HADDR[7:0])
      ADDR_ELEVATE: next_rdata[7:0]      = priority_elevate_reg;
      ADDR_WDOG:    next_rdata[7:0]      = watchdog_control_reg;
      ADDR_EN_LO:   next_rdata           = en_lo;
      ADDR_EN_HI:   next_rdata           = en_hi;
      ADDR_STATUS:  next_rdata[ST_W-1:0] = status;
      ADDR_MASK:    next_rdata[ST_W-1:0] = mask;
      ADDR_VECTOR:  next_rdata[16:0]     = {VECTOR_VALID, VECTOR_ADDR};
      ADDR_MODE:    next_rdata[MODE_W-1:0] = PORT_MODE;
      default:      next_rdata           = '0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      HRDATA <= '0;
    end else if (ap_take && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // Slot masks: reserved or non-maskable slots never request
  genvar s;
  generate
    for (s = 0; s < SLOTS; s++) begin : g_slot
      assign usable[s] = (6'(s) <= SLOT_LAST) & ~SLOT_RSVD[s];
    end
  endgenerate

  // Named enables SLOT_PA_OVF, SLOT_PA_EDGE, SLOT_MOTOR, SLOT_LOW_SUP
  // live in the local enable words like every other source
  assign local_en = {en_hi, en_lo};
  assign pending  = PERIPH_REQ & local_en & usable & {SLOTS{~STATUS_I_MASK}};

  vprs_arb u_arb (
    .pending (pending),
    .elevate (priority_elevate_reg),
    .hit     (mask_hit),
    .slot    (mask_slot)
  );

  // Non-maskable qualifiers
  assign rst_main = RESET_CAUSE.por | RESET_CAUSE.ext_pin | RESET_CAUSE.low_supply;
  assign clk_ok   = RESET_CAUSE.clk_fail &
                    (watchdog_control_reg[WDOG_CME] | watchdog_control_reg[WDOG_FORCED_CLOCK_MONITOR_EN]);
  assign wdog_ok  = RESET_CAUSE.wdog_timeout &
                    (watchdog_control_reg[WDOG_RATE_W-1:0] != '0);
  assign nonmaskable_request_pin_ok  = NONMASKABLE_REQUEST_PIN & ~STATUS_X_MASK;
  assign nm_any   = rst_main | clk_ok | wdog_ok | UNIMPL_OPCODE_TRAP |
                    SOFTWARE_TRAP_INSTR | nonmaskable_request_pin_ok;

  // Priority chain, highest vector first
  always_comb begin
    next_valid  = 1'b1;
    if (rst_main) begin
      next_vector = VEC_RESET;
    end else if (clk_ok) begin
      next_vector = VEC_CLKMON;
    end else if (wdog_ok) begin
      next_vector = VEC_WDOG;
    end else if (UNIMPL_OPCODE_TRAP) begin
      next_vector = VEC_UNIMPL;
    end else if (SOFTWARE_TRAP_INSTR) begin
      next_vector = VEC_SWI;
    end else if (nonmaskable_request_pin_ok) begin
      next_vector = VEC_NONMASKABLE_REQUEST_PIN;
    end else if (mask_hit) begin
      next_vector = {VEC_HIGH, 1'b1, mask_slot, 1'b0};
    end else begin
      next_valid  = 1'b0;
      next_vector = '0;
    end
  end

  // Control state only; no data array is held here or cleared
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      VECTOR_ADDR  <= '0;
      VECTOR_VALID <= 1'b0;
    end else begin
      VECTOR_ADDR  <= next_vector;
      VECTOR_VALID <= next_valid;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SYSTEM_RESET_REQ <= 1'b0;
    end else begin
      SYSTEM_RESET_REQ <= rst_main | clk_ok | wdog_ok;
    end
  end

  // Events are rising edges of each qualified cause
  assign ev_now[ST_RESET]    = rst_main;
  assign ev_now[ST_CLKMON]   = clk_ok;
  assign ev_now[ST_WDOG]     = wdog_ok;
  assign ev_now[ST_NONMASKABLE_REQUEST_PIN]     = nonmaskable_request_pin_ok;
  assign ev_now[ST_MASKABLE] = mask_hit;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ev_prev <= '0;
    end else begin
      ev_prev <= ev_now;
    end
  end

  assign st_set = ev_now & ~ev_prev;
  // A status read clears all bits; a coinciding event survives
  assign st_clr = {ST_W{ap_take & ~HWRITE & (HADDR[7:0] == ADDR_STATUS)}};

  vprs_sticky #(.W(ST_W)) u_status (
    .clk (CLOCK),
    .rst (RST),
    .set (st_set),
    .clr (st_clr),
    .q   (status)
  );

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status & mask);
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  logic [5:0] vec_slot;
  assign vec_slot = VECTOR_ADDR[6:1];

  chk_reset_top: assert property (rst_main |=> VECTOR_ADDR == VEC_RESET)
    else $error("main reset did not select top vector");
  chk_clkmon_gate: assert property (
    RESET_CAUSE.clk_fail && !rst_main && !watchdog_control_reg[WDOG_CME]
    && !watchdog_control_reg[WDOG_FORCED_CLOCK_MONITOR_EN] |=> VECTOR_ADDR != VEC_CLKMON)
    else $error("clock fail vectored while monitor disabled");
  chk_clkmon_rank: assert property (clk_ok && !rst_main |=> VECTOR_ADDR == VEC_CLKMON)
    else $error("clock fail reset lost its rank");
  chk_wdog_rate: assert property (
    RESET_CAUSE.wdog_timeout && !rst_main && !clk_ok
    |=> (VECTOR_ADDR == VEC_WDOG) == $past(watchdog_control_reg[WDOG_RATE_W-1:0] != '0))
    else $error("watchdog vector not tied to rate");
  chk_unimpl_trap: assert property (
    UNIMPL_OPCODE_TRAP && !rst_main && !clk_ok && !wdog_ok |=> VECTOR_ADDR == VEC_UNIMPL)
    else $error("unimplemented opcode trap masked");
  chk_swi_always: assert property (
    SOFTWARE_TRAP_INSTR && !UNIMPL_OPCODE_TRAP && !rst_main && !clk_ok && !wdog_ok
    |=> VECTOR_ADDR == VEC_SWI)
    else $error("software trap did not vector");
  chk_nonmaskable_request_pin_mask: assert property (
    NONMASKABLE_REQUEST_PIN && STATUS_X_MASK |=> VECTOR_ADDR != VEC_NONMASKABLE_REQUEST_PIN)
    else $error("pin request passed the X mask");
  chk_imask_block: assert property (STATUS_I_MASK && !nm_any |=> !VECTOR_VALID)
    else $error("maskable request passed the I mask");
  chk_elevate_win: assert property (
    !nm_any && priority_elevate_reg[7] && !priority_elevate_reg[0]
    && pending[priority_elevate_reg[6:1]]
    |=> VECTOR_ADDR[7:0] == $past(priority_elevate_reg))
    else $error("elevated source did not win");
  chk_high_byte: assert property (VECTOR_VALID |-> VECTOR_ADDR[15:8] == VEC_HIGH)
    else $error("vector high byte wrong");
  chk_rsvd_quiet: assert property (
    VECTOR_VALID && VECTOR_ADDR[7] && vec_slot <= SLOT_LAST |-> !SLOT_RSVD[vec_slot])
    else $error("reserved slot won arbitration");
  chk_irq_level: assert property (|(status & mask) |=> IRQ)
    else $error("interrupt output missed a masked status");
  chk_sysreq_level: assert property (rst_main || clk_ok || wdog_ok |=> SYSTEM_RESET_REQ)
    else $error("qualified reset cause raised no system reset request");
  chk_strap_hold: assert property (strap_taken |=> $stable(PORT_MODE))
    else $error("port mode changed without a reset");

  // Named sources may only win through their own enable and request
  chk_pa_ovf_gate: assert property (
    VECTOR_ADDR == {VEC_HIGH, 1'b1, SLOT_PA_OVF, 1'b0}
    |-> $past(local_en[SLOT_PA_OVF] & PERIPH_REQ[SLOT_PA_OVF] & ~STATUS_I_MASK))
    else $error("accumulator overflow won without its enable");
  chk_pa_edge_gate: assert property (
    VECTOR_ADDR == {VEC_HIGH, 1'b1, SLOT_PA_EDGE, 1'b0}
    |-> $past(local_en[SLOT_PA_EDGE] & PERIPH_REQ[SLOT_PA_EDGE] & ~STATUS_I_MASK))
    else $error("accumulator edge won without its enable");
  chk_motor_gate: assert property (
    VECTOR_ADDR == {VEC_HIGH, 1'b1, SLOT_MOTOR, 1'b0}
    |-> $past(local_en[SLOT_MOTOR] & PERIPH_REQ[SLOT_MOTOR] & ~STATUS_I_MASK))
    else $error("motor overflow won without its enable");
  chk_low_supply_gate: assert property (
    VECTOR_ADDR == {VEC_HIGH, 1'b1, SLOT_LOW_SUP, 1'b0}
    |-> $past(local_en[SLOT_LOW_SUP] & PERIPH_REQ[SLOT_LOW_SUP] & ~STATUS_I_MASK))
    else $error("low supply warning won without its enable");

  cov_reset_vec: cover property (rst_main ##1 VECTOR_ADDR == VEC_RESET);
  cov_elevated: cover property (mask_hit && priority_elevate_reg != ELEVATE_RST
    ##1 VECTOR_ADDR[7:0] == $past(priority_elevate_reg));
  cov_nonmaskable_request_pin: cover property (nonmaskable_request_pin_ok && !rst_main ##1 VECTOR_ADDR == VEC_NONMASKABLE_REQUEST_PIN);
  cov_irq: cover property (st_set[ST_MASKABLE] ##[1:4] IRQ);
endmodule

// [core/vprs_pkg.sv]
// Shared constants and carrier types of the vector priority selector
package vprs_pkg;
  // Fixed vector slots, highest priority first
  localparam logic [15:0] VEC_RESET  = 16'hfffe;
  localparam logic [15:0] VEC_CLKMON = 16'hfffc;
  localparam logic [15:0] VEC_WDOG   = 16'hfffa;
  localparam logic [15:0] VEC_UNIMPL = 16'hfff8;
  localparam logic [15:0] VEC_SWI    = 16'hfff6;
  localparam logic [15:0] VEC_NONMASKABLE_REQUEST_PIN   = 16'hfff4;
  localparam logic [7:0]  VEC_HIGH   = 8'hff;
  // Maskable slot s has vector low byte {1, s, 0}
  localparam int          SLOTS      = 64;
  localparam logic [5:0]  SLOT_LAST  = 6'h39;
  localparam logic [63:0] SLOT_RSVD  = 64'h0000_01e2_c00e_179f;
  localparam logic [5:0]  SLOT_PA_OVF   = 6'h2e;
  localparam logic [5:0]  SLOT_PA_EDGE  = 6'h2d;
  localparam logic [5:0]  SLOT_MOTOR    = 6'h0b;
  localparam logic [5:0]  SLOT_LOW_SUP  = 6'h05;
  localparam logic [7:0]  ELEVATE_RST   = 8'hf2;
  // Register byte offsets
  localparam logic [7:0]  ADDR_ELEVATE  = 8'h00;
  localparam logic [7:0]  ADDR_WDOG     = 8'h04;
  localparam logic [7:0]  ADDR_EN_LO    = 8'h08;
  localparam logic [7:0]  ADDR_EN_HI    = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  localparam logic [7:0]  ADDR_MASK     = 8'h14;
  localparam logic [7:0]  ADDR_VECTOR   = 8'h18;
  localparam logic [7:0]  ADDR_MODE     = 8'h1c;
  // Watchdog control fields
  localparam int          WDOG_CME      = 7;
  localparam int          WDOG_FORCED_CLOCK_MONITOR_EN     = 6;
  localparam int          WDOG_RATE_W   = 3;
  // Status and mask bits
  localparam int          ST_W          = 5;
  localparam int          ST_RESET      = 0;
  localparam int          ST_CLKMON     = 1;
  localparam int          ST_WDOG       = 2;
  localparam int          ST_NONMASKABLE_REQUEST_PIN       = 3;
  localparam int          ST_MASKABLE   = 4;
  localparam int          MODE_W        = 2;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic por;
    logic ext_pin;
    logic low_supply;
    logic clk_fail;
    logic wdog_timeout;
  } vprs_rst_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } vprs_aphase_t;
endpackage

// [core/vprs_sticky.sv]
// Sticky event flags, set wins over clear
`timescale 1ns/1ns
module vprs_sticky #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          q[i] <= 1'b0;
        end else if (set[i]) begin
          q[i] <= 1'b1;
        end else if (clr[i]) begin
          q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// [core/vprs_arb.sv]
// Maskable slot arbiter with one elevated slot
`timescale 1ns/1ns
module vprs_arb
  import vprs_pkg::*;
(
  input  wire logic [SLOTS-1:0] pending,
  input  wire logic [7:0]       elevate,
  output logic                  hit,
  output logic      [5:0]       slot
);
  logic elev_ok;

  // Higher slot index means higher vector address
  always_comb begin
    hit  = 1'b0;
    slot = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (pending[i]) begin
        hit  = 1'b1;
        slot = 6'(i);
      end
    end
    // A code that names no live slot changes nothing
    elev_ok = elevate[7] & ~elevate[0] & pending[elevate[6:1]];
    if (elev_ok) begin
      slot = elevate[6:1];
    end
  end
endmodule

// [verif/vprs_partner.sv]
// Model of the core status bits and the request sources facing the selector
`timescale 1ns/1ns
module vprs_partner
  import vprs_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Commands from the bench
  input  vprs_pkg::vprs_rst_t c_rst,
  input  wire logic        c_unimpl,
  input  wire logic        c_swi,
  input  wire logic        c_pin,
  input  wire logic        c_x,
  input  wire logic        c_i,
  input  wire logic [63:0] c_req,
  // Levels seen by the selector
  output vprs_pkg::vprs_rst_t o_rst = '0,
  output logic             o_unimpl = 1'b0,
  output logic             o_swi = 1'b0,
  output logic             o_pin = 1'b0,
  output logic             o_x = 1'b1,
  output logic             o_i = 1'b1,
  output logic      [63:0] o_req = 64'h0
);
  // Sources hold their requests as levels until the bench withdraws them
  always @(posedge clk) begin
    o_rst    <= c_rst;
    o_unimpl <= c_unimpl;
    o_swi    <= c_swi;
    o_pin    <= c_pin;
    o_x      <= c_x;
    o_i      <= c_i;
    o_req    <= c_req;
  end
endmodule

// [verif/vprs_top_tb.sv]
// Self-checking bench for the vector priority selector
`timescale 1ns/1ns
module vprs_top_tb;
  import vprs_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hresp, vvalid, sysreq, irq;
  logic c_unimpl, c_swi, c_pin, c_x, c_i, p_unimpl, p_swi, p_pin, p_x, p_i;
  logic [1:0] htrans, pmode, strap;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [63:0] c_req, p_req;
  logic [15:0] vec;
  vprs_rst_t c_rst, p_rst;
  int fail_count, comparisons;
  logic [7:0] codes [4] = '{8'h96, 8'h8a, 8'hd0, 8'hda};
  logic [15:0] wins [4] = '{16'hff96, 16'hff8a, 16'hffdc, 16'hffda};

  vprs_partner part_u (.clk(clk), .c_rst(c_rst), .c_unimpl(c_unimpl), .c_swi(c_swi),
    .c_pin(c_pin), .c_x(c_x), .c_i(c_i), .c_req(c_req), .o_rst(p_rst),
    .o_unimpl(p_unimpl), .o_swi(p_swi), .o_pin(p_pin), .o_x(p_x), .o_i(p_i), .o_req(p_req));

  vprs_top dut_u (.CLOCK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .RESET_CAUSE(p_rst), .UNIMPL_OPCODE_TRAP(p_unimpl),
    .SOFTWARE_TRAP_INSTR(p_swi), .NONMASKABLE_REQUEST_PIN(p_pin), .STATUS_X_MASK(p_x),
    .STATUS_I_MASK(p_i), .PERIPH_REQ(p_req), .MODE_STRAP(strap), .VECTOR_ADDR(vec),
    .VECTOR_VALID(vvalid), .SYSTEM_RESET_REQ(sysreq), .PORT_MODE(pmode), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0);
    chk(what, r, exp);
  endtask

  // Vector and valid lag inputs by the model's edge plus the selector's edge; IRQ lags by one edge more
  task automatic vchk(input logic [15:0] exp, input logic ir);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("vector", {16'h0, vec}, {16'h0, exp});
    chk("valid", {31'h0, vvalid}, {31'h0, exp != 16'h0});
    chk("irq", {31'h0, irq}, {31'h0, ir});
    @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 36'h0, 32'h0, 3'b010};
    {c_unimpl, c_swi, c_pin, c_x, c_i, c_req} = {5'b00011, 64'h0};
    c_rst = '0;
    strap = 2'b10;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("reset out", {hready, hresp, vvalid, sysreq, irq}, 32'h10);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("port mode", {30'h0, pmode}, 32'h2);
    rdc(ADDR_ELEVATE, 32'hf2, "elevate");
    rdc(ADDR_MODE, 32'h2, "mode reg");
    rdc(8'h20, 32'h0, "unmapped");
    bus(ADDR_WDOG, 1'b1, 32'h81);
    c_rst <= 5'b11111;
    vchk(VEC_RESET, 1'b0);
    chk("sysreq", {31'h0, sysreq}, 32'h1);
    c_rst <= 5'b00011;
    vchk(VEC_CLKMON, 1'b0);
    c_rst <= 5'b00001;
    vchk(VEC_WDOG, 1'b0);
    for (int i = 2; i < 5; i++) begin
      c_rst <= 5'b00001 << i;
      vchk(VEC_RESET, 1'b0);
    end
    bus(ADDR_WDOG, 1'b1, 32'h40);
    c_rst <= 5'b00011;
    vchk(VEC_CLKMON, 1'b0);
    bus(ADDR_WDOG, 1'b1, 32'h0);
    vchk(16'h0, 1'b0);
    c_rst <= '0;
    {c_unimpl, c_swi, c_pin} <= 3'b111;
    vchk(VEC_UNIMPL, 1'b0);
    c_unimpl <= 1'b0;
    vchk(VEC_SWI, 1'b0);
    c_swi <= 1'b0;
    vchk(16'h0, 1'b0);
    c_x <= 1'b0;
    vchk(VEC_NONMASKABLE_REQUEST_PIN, 1'b0);
    c_pin <= 1'b0;
    // Slots 46, 45, reserved 40, 11 and 5 enabled and requesting
    bus(ADDR_EN_HI, 1'b1, 32'h6100);
    bus(ADDR_EN_LO, 1'b1, 32'h0820);
    c_req <= 64'h0000_6100_0000_0820;
    vchk(16'h0, 1'b0);
    c_i <= 1'b0;
    vchk(16'hffdc, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bus(ADDR_ELEVATE, 1'b1, {24'h0, codes[i]});
      vchk(wins[i], 1'b0);
    end
    bus(ADDR_ELEVATE, 1'b1, 32'hf2);
    bus(ADDR_EN_HI, 1'b1, 32'h0100);
    vchk(16'hff96, 1'b0);
    c_req <= 64'h0;
    bus(ADDR_MASK, 1'b1, 32'h10);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    rdc(ADDR_STATUS, 32'h0, "status cleared");
    c_req <= 64'h20;
    vchk(16'hff8a, 1'b1);
    rdc(ADDR_VECTOR, 32'h0001ff8a, "vector reg");
    rdc(ADDR_STATUS, 32'h10, "status");
    vchk(16'hff8a, 1'b0);
    // A masked event leaves IRQ low but still records status
    bus(ADDR_MASK, 1'b1, 32'h0);
    c_req <= 64'h0;
    repeat (3) @(posedge clk);
    c_req <= 64'h20;
    vchk(16'hff8a, 1'b0);
    rdc(ADDR_STATUS, 32'h10, "masked status");
    // A new strap is only caught by the next reset
    strap <= 2'b01;
    rdc(ADDR_MODE, 32'h2, "mode held");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("new mode", {30'h0, pmode}, 32'h1);
    chk("reset again", {29'h0, vvalid, sysreq, irq}, 32'h0);
    rdc(ADDR_EN_LO, 32'h0, "enables");
    rdc(ADDR_ELEVATE, 32'hf2, "elevate again");
    tally_and_finish();
  end
endmodule
